/* File: rct16_timer.sv */
// Sixteen-bit reload/capture timer with AXI4-Lite register access
// Contract
// - Timer mode steps every twelve clocks
// - Counter mode counts count pin falling edges
// - Counter events at most one per 24; the logic here accepts one per two clocks
// - Plain reload mode counts up only
// - Reload on overflow, optionally trigger edge
// - Up reload value comes from register
// - Plain reload events raise interrupt
// - Up/down direction follows trigger pin level
// - Up/down mode raises no reload interrupt
// - Up/down upward reloads on overflow only
// - Down counting underflows at register value
// - Underflow reloads fixed FFFF
// - Capture mode counts from zero, wraps
// - Capture edge copies count into register
// - Capture mode interrupts on overflow, capture
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rct16_cfg.svh"
module rct16_timer (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic ext_count_pin,
  input wire logic ext_trigger_pin,
  // Interrupt
  output logic irq
);

  logic [5:0] ctrl_reg;
  logic [15:0] reload_capture_value_reg;
  logic [15:0] count_reg;
  logic [3:0] status_reg;
  logic [3:0] irq_en_reg;
  logic [3:0] div_reg;
  logic [2:0] cnt_sync_reg;
  logic [2:0] trg_sync_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Write a 32-bit word under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // Decode a known register offset
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == `RCT16_OFF_CTRL) || (a == `RCT16_OFF_RCV) ||
      (a == `RCT16_OFF_COUNT) || (a == `RCT16_OFF_STATUS) ||
      (a == `RCT16_OFF_CLEAR) || (a == `RCT16_OFF_IRQ_EN);
  endfunction : addr_ok

  // Match a completed write against one register offset
  function automatic logic wr_hit(input logic fire, input logic [7:0] a,
      input logic [7:0] off);
    return fire && (a == off);
  endfunction : wr_hit

  // Control field aliases
  logic run_on;
  logic mode_capture;
  logic mode_counter;
  logic updown_on;
  logic trig_en;
  logic trig_rise;
  assign run_on = ctrl_reg[`RCT16_CTRL_RUN];
  assign mode_capture = ctrl_reg[`RCT16_CTRL_CAPTURE];
  assign mode_counter = ctrl_reg[`RCT16_CTRL_COUNTER];
  assign updown_on = ctrl_reg[`RCT16_CTRL_UPDOWN];
  assign trig_en = ctrl_reg[`RCT16_CTRL_TRIG_EN];
  assign trig_rise = ctrl_reg[`RCT16_CTRL_TRIG_RISE];

  // Pin synchronisers, third stage holds the previous sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_sync_reg <= 3'h7;
      trg_sync_reg <= 3'h7;
    end else if (clk_en) begin
      cnt_sync_reg <= {cnt_sync_reg[1:0], ext_count_pin};
      trg_sync_reg <= {trg_sync_reg[1:0], ext_trigger_pin};
    end
  end

  logic cnt_fall;
  logic trg_level;
  logic trg_edge;
  assign cnt_fall = cnt_sync_reg[2] & ~cnt_sync_reg[1];
  assign trg_level = trg_sync_reg[1];
  logic trg_rise_seen;
  logic trg_fall_seen;
  assign trg_rise_seen = ~trg_sync_reg[2] & trg_sync_reg[1];
  assign trg_fall_seen = trg_sync_reg[2] & ~trg_sync_reg[1];
  assign trg_edge = trig_rise ? trg_rise_seen : trg_fall_seen;

  // Prescale by twelve in timer mode
  logic div_tick;
  assign div_tick = (div_reg == `RCT16_TIMER_DIV - 4'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 4'h0;
    end else if (clk_en) begin
      if (!run_on || mode_counter || div_tick) begin
        div_reg <= 4'h0;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end

  // Count step; pin edges need one clock each level, so one per two clocks at most
  logic step;
  logic timer_step;
  logic pin_step;
  assign timer_step = !mode_counter && div_tick;
  assign pin_step = mode_counter && cnt_fall;
  assign step = run_on && (timer_step || pin_step);

  // Count engine events
  logic dir_down;
  logic at_max;
  logic at_floor;
  logic ev_ovf;
  logic ev_unf;
  logic ev_trig_reload;
  logic ev_capture;
  assign dir_down = !mode_capture && updown_on && !trg_level;
  assign at_max = (count_reg == `RCT16_CNT_MAX);
  assign at_floor = (count_reg == reload_capture_value_reg);
  assign ev_ovf = step && !dir_down && at_max;
  assign ev_unf = step && dir_down && at_floor;
  assign ev_trig_reload = run_on && !mode_capture && !updown_on &&
    trig_en && trg_edge;
  assign ev_capture = run_on && mode_capture && trg_edge;

  // Next count value
  logic [15:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (ev_trig_reload) begin
      count_next = reload_capture_value_reg;
    end else if (ev_ovf) begin
      count_next = mode_capture ? `RCT16_CNT_MIN :
        reload_capture_value_reg;
    end else if (ev_unf) begin
      count_next = `RCT16_CNT_MAX;
    end else if (step) begin
      count_next = dir_down ? count_reg - 16'h1 : count_reg + 16'h1;
    end
  end

  // Bus write decode
  logic wr_fire;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  logic [31:0] wr_word;
  assign wr_word = strb_merge(32'h0, w_data_reg, w_strb_reg);

  // Per-register write strobes
  logic wr_ctrl;
  logic wr_rcv;
  logic wr_count;
  logic wr_clear;
  logic wr_irq_en;
  assign wr_ctrl = wr_hit(wr_fire, aw_addr_reg, `RCT16_OFF_CTRL);
  assign wr_rcv = wr_hit(wr_fire, aw_addr_reg, `RCT16_OFF_RCV);
  assign wr_count = wr_hit(wr_fire, aw_addr_reg, `RCT16_OFF_COUNT);
  assign wr_clear = wr_hit(wr_fire, aw_addr_reg, `RCT16_OFF_CLEAR);
  assign wr_irq_en = wr_hit(wr_fire, aw_addr_reg, `RCT16_OFF_IRQ_EN);

  // Strobe-merged images of the writable registers
  logic [31:0] count_wr_word;
  logic [31:0] rcv_wr_word;
  logic [31:0] ctrl_wr_word;
  assign count_wr_word = strb_merge({16'h0, count_reg}, w_data_reg,
    w_strb_reg);
  assign rcv_wr_word = strb_merge({16'h0, reload_capture_value_reg},
    w_data_reg, w_strb_reg);
  assign ctrl_wr_word = strb_merge({26'h0, ctrl_reg}, w_data_reg,
    w_strb_reg);

  // Count register; software write beats a count step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 16'h0000;
    end else if (clk_en) begin
      if (wr_count) begin
        count_reg <= count_wr_word[15:0];
      end else begin
        count_reg <= count_next;
      end
    end
  end

  // Reload/capture value register; capture wins over software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_capture_value_reg <= 16'h0000;
    end else if (clk_en) begin
      if (ev_capture) begin
        reload_capture_value_reg <= count_reg;
      end else if (wr_rcv) begin
        reload_capture_value_reg <= rcv_wr_word[15:0];
      end
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 6'(`RCT16_CTRL_RST);
    end else if (clk_en && wr_ctrl) begin
      ctrl_reg <= ctrl_wr_word[5:0];
    end
  end

  // Interrupt enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg <= 4'h0;
    end else if (clk_en && wr_irq_en) begin
      irq_en_reg <= wr_word[3:0];
    end
  end

  // Sticky status flags; a new event beats a clear
  logic [3:0] ev_vec;
  logic [3:0] clr_vec;
  assign ev_vec[`RCT16_ST_OVF] = ev_ovf;
  assign ev_vec[`RCT16_ST_UNF] = ev_unf;
  assign ev_vec[`RCT16_ST_TRIG] = ev_trig_reload || ev_capture;
  logic irq_ev_plain;
  logic irq_ev_capture;
  assign irq_ev_plain = !mode_capture && !updown_on &&
    (ev_ovf || ev_trig_reload);
  assign irq_ev_capture = mode_capture && (ev_ovf || ev_capture);
  assign ev_vec[`RCT16_ST_IRQ] = irq_ev_plain || irq_ev_capture;
  assign clr_vec = wr_clear ? wr_word[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 4'h0;
    end else if (clk_en) begin
      status_reg <= (status_reg & ~clr_vec) | ev_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_reg & irq_en_reg);
    end
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_hold_reg <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_reg) ? rct16_pkg::RCT16_OKAY :
          rct16_pkg::RCT16_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  logic [31:0] rd_word;
  always_comb begin
    unique case (s_axi_araddr)
      `RCT16_OFF_CTRL: rd_word = {26'h0, ctrl_reg};
      `RCT16_OFF_RCV: rd_word = {16'h0, reload_capture_value_reg};
      `RCT16_OFF_COUNT: rd_word = {16'h0, count_reg};
      `RCT16_OFF_STATUS: rd_word = {28'h0, status_reg};
      `RCT16_OFF_IRQ_EN: rd_word = {28'h0, irq_en_reg};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? rct16_pkg::RCT16_OKAY :
          rct16_pkg::RCT16_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : rct16_timer
`default_nettype wire

/* File: rct16_cfg.svh */
// Register offsets, reset values and timing counts of the reload/capture timer
`ifndef RCT16_CFG_SVH
`define RCT16_CFG_SVH
`define RCT16_OFF_CTRL 8'h00
`define RCT16_OFF_RCV 8'h04
`define RCT16_OFF_COUNT 8'h08
`define RCT16_OFF_STATUS 8'h0c
`define RCT16_OFF_CLEAR 8'h10
`define RCT16_OFF_IRQ_EN 8'h14
`define RCT16_CTRL_RUN 0
`define RCT16_CTRL_CAPTURE 1
`define RCT16_CTRL_COUNTER 2
`define RCT16_CTRL_UPDOWN 3
`define RCT16_CTRL_TRIG_EN 4
`define RCT16_CTRL_TRIG_RISE 5
`define RCT16_CTRL_RST 32'h0000_0000
`define RCT16_ST_OVF 0
`define RCT16_ST_UNF 1
`define RCT16_ST_TRIG 2
`define RCT16_ST_IRQ 3
`define RCT16_TIMER_DIV 4'hc
`define RCT16_CNT_MAX 16'hffff
`define RCT16_CNT_MIN 16'h0000
`endif

/* File: rct16_pkg.sv */
// Types of the reload/capture timer
package rct16_pkg;
  typedef enum logic [1:0] {
    RCT16_OKAY = 2'b00,
    RCT16_SLVERR = 2'b10
  } rct16_resp_e;
endpackage : rct16_pkg

/* File: rct16_checker.sv */
// Port checks of the reload/capture timer
`timescale 1ns/100ps
`default_nettype none
module rct16_checker (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    && clk_en |=> s_axi_rvalid) else $error("no read answer");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  write_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && clk_en |-> ##[1:4] s_axi_bvalid)
    else $error("no write answer");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
    && clk_en && s_axi_araddr > 8'h14 |=> s_axi_rdata == 32'h0
    && s_axi_rresp == rct16_pkg::RCT16_SLVERR) else $error("bad unmapped");
  freeze_a: assert property (!clk_en |=> $stable(irq)
    && $stable(s_axi_bvalid) && $stable(s_axi_rvalid)) else $error("moved");
  aw_taken_a: assert property (s_axi_awvalid && s_axi_awready
    && clk_en |=> !s_axi_awready) else $error("awready stayed");
endmodule : rct16_checker
bind rct16_timer rct16_checker rct16_checker_inst (.aclk, .aresetn,
  .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

/* File: rct16_pins_model.sv */
// Model of the external count and trigger sources
`timescale 1ns/100ps
`default_nettype none
module rct16_pins_model (
  // Clock
  input wire logic aclk,
  // Pins
  output logic ext_count_pin,
  output logic ext_trigger_pin
);
  initial ext_count_pin <= 1'b1;
  initial ext_trigger_pin <= 1'b0;
  task automatic pulse(input int n);
    repeat (n) begin
      ext_count_pin <= 1'b0;
      repeat (12) @(posedge aclk);
      ext_count_pin <= 1'b1;
      repeat (12) @(posedge aclk);
    end
  endtask : pulse
  task automatic set_trig(input logic l);
    ext_trigger_pin <= l;
    repeat (6) @(posedge aclk);
  endtask : set_trig
endmodule : rct16_pins_model
`default_nettype wire

/* File: testbench.sv */
// Register-level tests of the reload/capture timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic aclk = 1'b0;
  logic aresetn;
  logic clk_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, ext_count_pin, ext_trigger_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #50 aclk = ~aclk;
  rct16_timer rct16_timer_inst (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_count_pin, .ext_trigger_pin, .irq);
  rct16_pins_model pins (.aclk, .ext_count_pin, .ext_trigger_pin);
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic b;
    b = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      b = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rc
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    aresetn <= 1'b0;
    clk_en <= 1'b1;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(8'h00, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h18, 32'h0);
    chk(32'(r), 32'(rct16_pkg::RCT16_SLVERR));
    wr(8'h18, 32'h1);
    chk(32'(r), 32'(rct16_pkg::RCT16_SLVERR));
    s_axi_wstrb <= 4'h1;
    wr(8'h04, 32'hffff_ffab);
    chk(32'(r), 32'(rct16_pkg::RCT16_OKAY));
    s_axi_wstrb <= 4'hf;
    rc(8'h04, 32'hab);
    chk(32'(r), 32'(rct16_pkg::RCT16_OKAY));
    clk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    clk_en <= 1'b1;
    wr(8'h04, 32'h1234);
    wr(8'h08, 32'hfffe);
    wr(8'h14, 32'h8);
    wr(8'h00, 32'h5);
    pins.pulse(2);
    rc(8'h08, 32'h1234);
    rc(8'h0c, 32'h9);
    chk(irq, 1'b1);
    wr(8'h10, 32'hf);
    rc(8'h0c, 32'h0);
    chk(irq, 1'b0);
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h35);
    pins.set_trig(1'b1);
    rc(8'h08, 32'h1234);
    rc(8'h0c, 32'hc);
    pins.set_trig(1'b0);
    wr(8'h10, 32'hf);
    wr(8'h00, 32'hd);
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h12);
    pins.pulse(2);
    rc(8'h08, 32'h10);
    pins.pulse(1);
    rc(8'h08, 32'hffff);
    pins.set_trig(1'b1);
    pins.pulse(1);
    rc(8'h08, 32'h10);
    rc(8'h0c, 32'h3);
    chk(irq, 1'b0);
    wr(8'h10, 32'hf);
    wr(8'h00, 32'h7);
    wr(8'h08, 32'hffff);
    pins.pulse(1);
    rc(8'h08, 32'h0);
    pins.pulse(3);
    pins.set_trig(1'b0);
    rc(8'h04, 32'h3);
    rc(8'h0c, 32'hd);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    repeat (240) @(posedge aclk);
    wr(8'h00, 32'h0);
    rd(8'h08);
    chk(v >= 32'd20 && v <= 32'd21, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
